/* File: inc/sdram_cmd_pkg.sv */
package sdram_cmd_pkg;

	// command encodings on {ras, cas, we}, chip select low
	localparam logic [2:0] CODE_NOP       = 3'h7;
	localparam logic [2:0] CODE_BURST_STOP = 3'h6;
	localparam logic [2:0] CODE_READ      = 3'h5;
	localparam logic [2:0] CODE_WRITE     = 3'h4;
	localparam logic [2:0] CODE_ACTIVATE  = 3'h3;
	localparam logic [2:0] CODE_PRECHARGE = 3'h2;
	localparam logic [2:0] CODE_REFRESH   = 3'h1;
	localparam logic [2:0] CODE_MODE_LOAD = 3'h0;

	// address pin positions
	localparam int BANK_BIT     = 9;
	localparam int AUTO_PRE_BIT = 8;

	// operating mode word fields
	localparam int WMODE_LSB   = 7;
	localparam int LAT_LSB     = 4;
	localparam int ORDER_BIT   = 3;
	localparam int BLEN_LSB    = 0;
	localparam logic [2:0] WMODE_BURST  = 3'h0;
	localparam logic [2:0] WMODE_SINGLE = 3'h4;
	localparam logic [2:0] BLEN_FULL    = 3'h7;

	// reset values
	localparam logic [9:0] MODE_RESET = 10'h020;
	localparam logic [8:0] COUNT_RESET = 9'h000;

	localparam int FULL_PAGE_WORDS = 256;

	typedef enum logic [5:0] {
		idle_type_st      = 6'h01,
		active_st         = 6'h02,
		read_st           = 6'h04,
		write_st          = 6'h08,
		read_then_close_state = 6'h10,
		write_close_st    = 6'h20
	} bank_state_type;

	typedef struct packed {
		logic       cs_n;
		logic       ras_n;
		logic       cas_n;
		logic       we_n;
		logic [9:0] addr;
	} cmd_bus_type;

	typedef struct packed {
		logic       bank;
		logic [7:0] column;
		logic       write;
	} beat_type;

endpackage

/* File: rtl/beat_fifo.sv */
`timescale 1ns/100ps
module beat_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	// fill side
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	// drain side
	output logic                  out_valid_out,
	output logic      [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	always_comb begin
		push = in_valid_in && (count != (AW+1)'(DEPTH));
		pop  = out_ready_in && (count != '0);
		next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
		next_count = count;
		if (push && !pop) begin
			next_count = (AW+1)'(count + 1'b1);
		end else if (pop && !push) begin
			next_count = (AW+1)'(count - 1'b1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			wr_ptr        <= '0;
			rd_ptr        <= '0;
			count         <= '0;
			in_ready_out  <= 1'b0;
			out_valid_out <= 1'b0;
			out_data_out  <= '0;
		end else begin
			wr_ptr        <= next_wr_ptr;
			rd_ptr        <= next_rd_ptr;
			count         <= next_count;
			in_ready_out  <= next_count != (AW+1)'(DEPTH);
			out_valid_out <= pop;
			out_data_out  <= store[rd_ptr];
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) begin
			store[wr_ptr] <= in_data_in;
		end
	end
endmodule

/* File: rtl/sdram_command_core.sv */
`timescale 1ns/100ps
// Functional notes
// - decode select and three strobes per edge
// - a9 bank, a7-a0 column, a8 autoprecharge
// - activate idle bank, other bank unchanged
// - precharge a8 both, else a9 bank
// - mode load captures a9-a0 fields
// - first read beat after read latency
// - internal column generation, programmable burst length
// - sequential or interleaved column order
// - burst write starts one cycle after the command, like read latency 1
// - single write mode stores one word
// - full page covers 256 wrapping columns
module sdram_command_core
	import sdram_cmd_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	// command pins
	input  wire logic        cs_n_in,
	input  wire logic        ras_n_in,
	input  wire logic        cas_n_in,
	input  wire logic        we_n_in,
	input  wire logic [9:0]  addr_in,
	// beat stream out
	output logic             beat_valid_out,
	output logic             beat_bank_out,
	output logic [7:0]       beat_column_out,
	output logic             beat_write_out,
	input  wire logic        beat_ready_in,
	// state view
	output logic [9:0]       mode_word_out,
	output bank_state_type   bank0_state_out,
	output bank_state_type   bank1_state_out,
	output logic             burst_busy_out
);
	cmd_bus_type    pin_meta;
	cmd_bus_type    pin;
	bank_state_type bank_st [2];
	bank_state_type next_bank_st [2];
	logic [9:0]     operating_mode_word;
	logic [9:0]     next_mode;
	// burst generator
	logic           busy;
	logic           next_busy;
	logic           b_bank;
	logic           next_b_bank;
	logic [7:0]     b_start;
	logic [7:0]     next_b_start;
	logic [8:0]     b_idx;
	logic [8:0]     next_b_idx;
	logic [8:0]     b_len;
	logic [8:0]     next_b_len;
	logic           b_write;
	logic           next_b_write;
	logic [2:0]     b_delay;
	logic [2:0]     next_b_delay;
	logic           b_issue;
	logic [7:0]     b_col;
	logic [7:0]     b_mask;
	logic [2:0]     cmd;
	logic           sel;
	logic           stall;
	logic           fifo_ready;
	beat_type       beat_in;
	beat_type       beat_out;
	logic           fifo_valid;

	// pins come from another chip: two stages
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pin_meta <= '1;
			pin      <= '1;
		end else begin
			pin_meta <= {cs_n_in, ras_n_in, cas_n_in, we_n_in, addr_in};
			pin      <= pin_meta;
		end
	end

	function automatic logic [8:0] burst_words(input logic [2:0] code);
		unique case (code)
			3'h0: burst_words = 9'h001;
			3'h1: burst_words = 9'h002;
			3'h2: burst_words = 9'h004;
			3'h3: burst_words = 9'h008;
			default: burst_words = 9'(FULL_PAGE_WORDS);
		endcase
	endfunction

	always_comb begin
		cmd = {pin.ras_n, pin.cas_n, pin.we_n};
		sel = pin.addr[BANK_BIT];
		next_bank_st = bank_st;
		next_mode    = operating_mode_word;
		next_busy    = busy;
		next_b_bank  = b_bank;
		next_b_start = b_start;
		next_b_idx   = b_idx;
		next_b_len   = b_len;
		next_b_write = b_write;
		next_b_delay = b_delay;
		b_issue = busy && (b_delay == 3'h0) && !stall;
		b_mask = 8'(b_len - 1'b1);
		if (operating_mode_word[ORDER_BIT]) begin
			b_col = b_start ^ b_idx[7:0];
		end else begin
			// sequential wraps inside the burst-length block, not the row
			b_col = (b_start & ~b_mask) | (8'(b_start + b_idx[7:0]) & b_mask);
		end
		if (!busy) begin
		end else if (b_delay != 3'h0) begin
			next_b_delay = 3'(b_delay - 1'b1);
		end else if (b_issue) begin
			if (9'(b_idx + 1'b1) == b_len && b_len != 9'(FULL_PAGE_WORDS)) begin
				next_busy = 1'b0;
				if (bank_st[b_bank] inside {read_then_close_state, write_close_st}) begin
					next_bank_st[b_bank] = idle_type_st;
				end else if (bank_st[b_bank] inside {read_st, write_st}) begin
					next_bank_st[b_bank] = active_st;
				end
			end else begin
				next_b_idx = 9'(b_idx + 1'b1);
			end
		end
		if (!pin.cs_n) begin
			unique case (cmd)
				CODE_BURST_STOP: begin
					next_busy = 1'b0;
					for (int i = 0; i < 2; i++) begin
						if (bank_st[i] inside {read_st, write_st}) begin
							next_bank_st[i] = active_st;
						end
					end
				end
				CODE_READ, CODE_WRITE: begin
					for (int i = 0; i < 2; i++) begin
						if (bank_st[i] inside {read_st, write_st}) begin
							next_bank_st[i] = active_st;
						end
					end
					if (cmd == CODE_READ) begin
						next_bank_st[sel] = pin.addr[AUTO_PRE_BIT] ? read_then_close_state : read_st;
					end else begin
						next_bank_st[sel] = pin.addr[AUTO_PRE_BIT] ? write_close_st : write_st;
					end
					next_busy    = 1'b1;
					next_b_bank  = sel;
					next_b_start = pin.addr[7:0];
					next_b_idx   = COUNT_RESET;
					next_b_write = cmd == CODE_WRITE;
					next_b_len = burst_words(operating_mode_word[BLEN_LSB +: 3]);
					if (cmd == CODE_WRITE &&
					    operating_mode_word[WMODE_LSB +: 3] == WMODE_SINGLE) begin
						next_b_len = 9'h001;
					end
					if (cmd == CODE_WRITE) begin
						next_b_delay = 3'h0;
					end else begin
						next_b_delay = 3'(operating_mode_word[LAT_LSB +: 3] - 1'b1);
					end
				end
				CODE_ACTIVATE: begin
					if (bank_st[sel] == idle_type_st) begin
						next_bank_st[sel] = active_st;
					end
				end
				CODE_PRECHARGE: begin
					if (pin.addr[AUTO_PRE_BIT]) begin
						next_bank_st[0] = idle_type_st;
						next_bank_st[1] = idle_type_st;
						next_busy = 1'b0;
					end else begin
						next_bank_st[sel] = idle_type_st;
						if (b_bank == sel) begin
							next_busy = 1'b0;
						end
					end
				end
				CODE_MODE_LOAD: begin
					next_mode = pin.addr;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			bank_st[0]          <= idle_type_st;
			bank_st[1]          <= idle_type_st;
			operating_mode_word <= MODE_RESET;
			busy                <= 1'b0;
			b_bank              <= 1'b0;
			b_start             <= 8'h00;
			b_idx               <= COUNT_RESET;
			b_len               <= COUNT_RESET;
			b_write             <= 1'b0;
			b_delay             <= 3'h0;
			mode_word_out       <= MODE_RESET;
			bank0_state_out     <= idle_type_st;
			bank1_state_out     <= idle_type_st;
			burst_busy_out      <= 1'b0;
		end else begin
			bank_st             <= next_bank_st;
			operating_mode_word <= next_mode;
			busy                <= next_busy;
			b_bank              <= next_b_bank;
			b_start             <= next_b_start;
			b_idx               <= next_b_idx;
			b_len               <= next_b_len;
			b_write             <= next_b_write;
			b_delay             <= next_b_delay;
			mode_word_out       <= next_mode;
			bank0_state_out     <= next_bank_st[0];
			bank1_state_out     <= next_bank_st[1];
			burst_busy_out      <= next_busy;
		end
	end

	// fifo full stalls the column generator, never drops a beat
	assign stall   = !fifo_ready;
	assign beat_in = '{bank: b_bank, column: b_col, write: b_write};

	beat_fifo #(
		.WIDTH ($bits(beat_type)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_in),
		.reset_in      (reset_in),
		.in_valid_in   (b_issue),
		.in_data_in    (beat_in),
		.in_ready_out  (fifo_ready),
		.out_valid_out (fifo_valid),
		.out_data_out  (beat_out),
		.out_ready_in  (beat_ready_in)
	);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			beat_valid_out  <= 1'b0;
			beat_bank_out   <= 1'b0;
			beat_column_out <= 8'h00;
			beat_write_out  <= 1'b0;
		end else begin
			beat_valid_out  <= fifo_valid;
			beat_bank_out   <= beat_out.bank;
			beat_column_out <= beat_out.column;
			beat_write_out  <= beat_out.write;
		end
	end
endmodule

/* File: verif/sdram_command_core_assertions.sv */
`timescale 1ns/100ps
module sdram_command_core_checker
	import sdram_cmd_pkg::*;
(
	// clock, reset and pins
	input wire logic           clk_in,
	input wire logic           reset_in,
	input wire logic           cs_n_in,
	input wire logic           ras_n_in,
	input wire logic           cas_n_in,
	input wire logic           we_n_in,
	input wire logic [9:0]     addr_in,
	// observed outputs
	input wire logic           beat_valid_out,
	input wire logic           burst_busy_out,
	input wire logic [9:0]     mode_word_out,
	input wire bank_state_type bank0_state_out,
	input wire bank_state_type bank1_state_out
);
	logic [3:0] cmd;
	logic [9:0] load_word;
	logic       b0_open;
	logic       b1_open;
	assign cmd = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
	assign b0_open = bank0_state_out == active_st;
	assign b1_open = bank1_state_out == active_st;
	// word seen with the last mode load
	always_ff @(posedge clk_in)
		if (cmd == {1'b0, CODE_MODE_LOAD}) load_word <= addr_in;
	default clocking dc @(posedge clk_in); endclocking
	default disable iff (reset_in);
	a_mode_load:
		assert property (cmd == {1'b0, CODE_MODE_LOAD} |=> ##[1:4] mode_word_out == load_word)
		else $error("mode word not loaded");
	a_open_bank:
		assert property (cmd == {1'b0, CODE_ACTIVATE} && !addr_in[9]
			&& bank0_state_out == idle_type_st |-> ##[2:5] b0_open)
		else $error("activate missed");
	a_pre_both:
		assert property (cmd == {1'b0, CODE_PRECHARGE} && addr_in[8] |-> ##[2:5]
			bank0_state_out == idle_type_st && bank1_state_out == idle_type_st)
		else $error("precharge all missed");
	a_pre_single:
		assert property (cmd == {1'b0, CODE_PRECHARGE} && addr_in[9:8] == 2'b10 && b0_open
			&& b1_open |-> ##[2:5] b0_open && bank1_state_out == idle_type_st)
		else $error("precharge one bank wrong");
	a_read_plain:
		assert property (cmd == {1'b0, CODE_READ} && addr_in[9:8] == 2'b00 && b0_open
			|-> ##[2:5] bank0_state_out == read_st)
		else $error("read state missed");
	a_read_close:
		assert property (cmd == {1'b0, CODE_READ} && addr_in[9:8] == 2'b11 && b1_open
			|-> ##[2:5] bank1_state_out == read_then_close_state)
		else $error("read close state missed");
	a_write_close:
		assert property (cmd == {1'b0, CODE_WRITE} && addr_in[9:8] == 2'b01 && b0_open
			|-> ##[2:5] bank0_state_out == write_close_st)
		else $error("write close state missed");
	a_write_plain:
		assert property (cmd == {1'b0, CODE_WRITE} && addr_in[9:8] == 2'b10 && b1_open
			|-> ##[2:5] bank1_state_out == write_st)
		else $error("write state missed");
	a_reset_clear:
		assert property (disable iff (1'b0) reset_in |=> bank0_state_out == idle_type_st
			&& bank1_state_out == idle_type_st && mode_word_out == MODE_RESET
			&& !beat_valid_out && !burst_busy_out)
		else $error("reset state wrong");
endmodule
bind sdram_command_core sdram_command_core_checker i_sdram_command_core_checker (
	.clk_in(clk_in), .reset_in(reset_in), .cs_n_in(cs_n_in), .ras_n_in(ras_n_in),
	.cas_n_in(cas_n_in), .we_n_in(we_n_in), .addr_in(addr_in),
	.beat_valid_out(beat_valid_out), .burst_busy_out(burst_busy_out),
	.mode_word_out(mode_word_out), .bank0_state_out(bank0_state_out),
	.bank1_state_out(bank1_state_out));

/* File: verif/sdram_ctl_model.sv */
`timescale 1ns/100ps
module sdram_ctl_model
	import sdram_cmd_pkg::*;
#(
	parameter int HOLD_CYCLES = 2000
) (
	// clock
	input  wire logic clk_in,
	// command pins
	output cmd_bus_type cmd_out
);
	initial cmd_out = {1'b1, 3'h7, 10'h3ff};
	task automatic issue(input logic [2:0] code, input logic [9:0] addr);
		@(negedge clk_in);
		cmd_out = {1'b0, code, addr};
		@(negedge clk_in);
		// deselected pins carry junk, never the last value
		cmd_out = {1'b1, ~code, ~addr};
		repeat (6) @(negedge clk_in);
	endtask
	// power-on order; clock gate and mask pins not modelled
	// hold of 100 us is 2000 cycles at 50 ns
	task automatic power_up(input logic [9:0] mode, input logic mode_first);
		repeat (HOLD_CYCLES) @(negedge clk_in);
		issue(CODE_PRECHARGE, 10'h100);
		if (mode_first) issue(CODE_MODE_LOAD, mode);
		repeat (2) issue(CODE_REFRESH, 10'h000);
		if (!mode_first) issue(CODE_MODE_LOAD, mode);
	endtask
endmodule

/* File: verif/tb.sv */
`timescale 1ns/100ps
module tb;
	import sdram_cmd_pkg::*;
	logic           clk_in = 1'b0;
	logic           reset_in = 1'b1;
	logic           beat_ready_in = 1'b1;
	cmd_bus_type    cmd;
	logic           beat_valid_out;
	logic           bb;
	logic [7:0]     bc;
	logic           bw;
	logic [9:0]     mode_word_out;
	bank_state_type bank0_state_out;
	bank_state_type bank1_state_out;
	logic           burst_busy_out;
	beat_type       got[$];
	int             bad_count = 0;
	int             check_count = 0;
	logic [9:0]     mode;
	logic [2:0]     bl;
	logic [7:0]     col;
	logic           rw, bk, ap, il, sw;
	time            first_t;
	time            t_mark;
	int             lat_gap [2];

	sdram_command_core #(.FIFO_DEPTH(16)) i_sdram_command_core (
		.clk_in(clk_in), .reset_in(reset_in), .cs_n_in(cmd.cs_n), .ras_n_in(cmd.ras_n),
		.cas_n_in(cmd.cas_n), .we_n_in(cmd.we_n), .addr_in(cmd.addr),
		.beat_valid_out(beat_valid_out), .beat_bank_out(bb), .beat_column_out(bc),
		.beat_write_out(bw), .beat_ready_in(beat_ready_in), .mode_word_out(mode_word_out),
		.bank0_state_out(bank0_state_out), .bank1_state_out(bank1_state_out),
		.burst_busy_out(burst_busy_out));
	sdram_ctl_model #(.HOLD_CYCLES(2000)) u_ctl (.clk_in(clk_in), .cmd_out(cmd));

	always #25 clk_in = ~clk_in;
	// negedge: beat outputs settled mid-cycle
	always @(negedge clk_in)
		if (beat_valid_out === 1'b1) begin
			if (got.size() == 0) first_t = $time;
			got.push_back(beat_type'({bb, bc, bw}));
		end

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		check_count++;
		if (seen !== want) begin
			bad_count++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// bounded wait for the generator, then let the fifo drain
	task automatic settle();
		int n = 0;
		repeat (12) @(negedge clk_in);
		while (burst_busy_out !== 1'b0 && n < 2000) begin
			@(negedge clk_in);
			n++;
		end
		if (n >= 2000) begin
			bad_count++;
			final_report();
		end
		repeat (12) @(negedge clk_in);
	endtask
	function automatic logic [7:0] col_at(logic [7:0] s, int i, logic [2:0] b, logic x);
		logic [7:0] m;
		m = (b == BLEN_FULL) ? 8'hff : 8'((1 << b) - 1);
		return x ? (s & ~m) | ((s ^ 8'(i)) & m) : (s & ~m) | ((s + 8'(i)) & m);
	endfunction
	task automatic open_both(input logic [9:0] m);
		u_ctl.issue(CODE_PRECHARGE, 10'h100);
		u_ctl.issue(CODE_MODE_LOAD, m);
		u_ctl.issue(CODE_ACTIVATE, {1'b0, 9'($urandom)});
		u_ctl.issue(CODE_ACTIVATE, {1'b1, 9'($urandom)});
		got.delete();
	endtask

	initial begin
		void'($urandom(46));
		repeat (20) @(negedge clk_in);
		reset_in = 1'b0;
		check(16'(mode_word_out), 16'(MODE_RESET));
		mode = {WMODE_BURST, 3'h2, 1'b1, 3'h2};
		u_ctl.power_up(mode, 1'($urandom));
		check(16'(mode_word_out), 16'(mode));
		// every bank, auto-close and direction mix; reserved codes never drawn
		for (int k = 0; k < 16; k++) begin
			{ap, bk, rw} = 3'(k);
			bl = 3'($urandom_range(3, 0));
			il = 1'($urandom);
			sw = 1'($urandom);
			col = 8'($urandom);
			mode = {sw ? WMODE_SINGLE : WMODE_BURST, 3'($urandom_range(3, 1)), il, bl};
			open_both(mode);
			u_ctl.issue(rw ? CODE_WRITE : CODE_READ, {bk, ap, col});
			settle();
			check(16'(got.size()), (rw && sw) ? 16'h0001 : 16'(1 << bl));
			foreach (got[i]) check(16'(got[i]), 16'({bk, col_at(col, i, bl, il), rw}));
			check(16'(bk ? bank1_state_out : bank0_state_out), ap ? 16'h0001 : 16'h0002);
			check(16'(bk ? bank0_state_out : bank1_state_out), 16'h0002);
			check(16'(mode_word_out), 16'(mode));
		end
		// two reads, latency 1 then 3: first beat moves by two cycles
		for (int j = 0; j < 2; j++) begin
			open_both({WMODE_BURST, j ? 3'h3 : 3'h1, 1'b0, 3'h0});
			t_mark = $time;
			u_ctl.issue(CODE_READ, 10'h011);
			settle();
			lat_gap[j] = int'((first_t - t_mark) / 50);
		end
		check(16'(lat_gap[1] - lat_gap[0]), 16'h0002);
		// full page with the drain side stalled long enough to fill the fifo
		open_both({WMODE_BURST, 3'h2, 1'b0, BLEN_FULL});
		beat_ready_in = 1'b0;
		u_ctl.issue(CODE_READ, 10'h0fa);
		repeat (60) @(negedge clk_in);
		check(16'(burst_busy_out), 16'h0001);
		beat_ready_in = 1'b1;
		repeat (300) @(negedge clk_in);
		u_ctl.issue(CODE_BURST_STOP, 10'h000);
		settle();
		check(16'(got.size() > 256), 16'h0001);
		foreach (got[i]) check(16'(got[i]), 16'({1'b0, 8'(8'hfa + i), 1'b0}));
		u_ctl.issue(CODE_NOP, 10'h3ff);
		check(16'({bank0_state_out, bank1_state_out}), 16'h0082);
		u_ctl.issue(CODE_PRECHARGE, 10'h200);
		check(16'({bank0_state_out, bank1_state_out}), 16'h0081);
		u_ctl.issue(CODE_PRECHARGE, 10'h100);
		u_ctl.issue(CODE_REFRESH, 10'h000);
		check(16'({bank0_state_out, bank1_state_out}), 16'h0041);
		final_report();
	end
endmodule
